// ---- rtl/sbgp_pkg.sv ----
// Package for the six bit general purpose port.
// Assumes a single core clock and a synchronous active low reset.
package sbgp_pkg;
   // Port geometry
   localparam int SBGP_WIDTH = 6;
   localparam int SBGP_BYTE = 8;
   localparam logic [7:0] SBGP_FULL_MASK = 8'h3F;
   localparam logic [7:0] SBGP_SMALL_MASK = 8'h1F;
   // Register file locations
   localparam logic [7:0] SBGP_DATA_ADDR = 8'h05;
   localparam logic [7:0] SBGP_DIR_ADDR = 8'h85;
   // Reset values
   localparam logic [7:0] SBGP_DIR_RESET = 8'h3F;
   localparam logic [7:0] SBGP_LATCH_RESET = 8'h00;
   // Open drain pin that also carries the timer clock
   localparam int SBGP_OD_BIT = 4;

   // One access from the core to the register file
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [7:0] wmask;
   } sbgp_req_t;

   // Registered answer to the core
   typedef struct packed {
      logic valid;
      logic [7:0] rdata;
   } sbgp_rsp_t;
endpackage

// ---- rtl/sbgp_port.sv ----
// Six bit general purpose port with direction register and pin readback.
// Assumes the core reaches it through a one cycle register file access
// and that pin levels arrive as plain inputs, asynchronous to the core clock.
`timescale 1ns/1ns
`default_nettype none

module sbgp_port #(
   parameter bit FULL_VARIANT = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Core register file access
   input wire sbgp_pkg::sbgp_req_t core_req,
   output sbgp_pkg::sbgp_rsp_t core_rsp,
   // Peripheral ownership of pins
   input wire logic [5:0] periph_en,
   // Pad signals
   input wire logic [5:0] pin_in,
   output logic [5:0] pin_out,
   output logic [5:0] pin_oe_n,
   // Timer clock feed
   output logic timer_zero_clock_input
);
   import sbgp_pkg::*;

   // Notes for users of this port:
   //  - pin levels reach a read two cycles after they settle
   //  - a write merges those delayed levels, so a pin that was
   //    just driven may merge its old level into the latch
   //  - the open drain bit needs a board pull-up to read high
   //  - peripheral ownership only releases the driver; the
   //    pin still reads back through the synchroniser

   // Synchroniser stages
   logic [5:0] sync1_r;
   logic [5:0] pins_r;

   // Software visible state
   logic [5:0] first_port_data_r;
   logic [5:0] first_port_direction_r;

   // Next values of the state above
   logic [5:0] latch_nxt;
   logic [5:0] dir_nxt;
   logic [7:0] rdata_nxt;

   // Variant mask and access decode
   logic [5:0] impl;
   logic data_hit;
   logic dir_hit;
   logic rd_req;
   logic wr_req;

   // Read answer flops
   logic rsp_valid_r;
   logic [7:0] rsp_rdata_r;

   // Pad drive before the open drain override
   logic [5:0] drive_en;
   logic [5:0] pad_level;
   logic od_pull_low;

   // Bits that exist in the chosen variant
   function automatic logic [5:0] impl_bits(input bit full);
      logic [7:0] m;
      m = full ? SBGP_FULL_MASK : SBGP_SMALL_MASK;
      return m[5:0];
   endfunction

   // Address match of a valid access; used by both registers
   function automatic logic addr_hit(
      input sbgp_req_t req,
      input logic [7:0] loc
   );
      return req.valid && (req.addr == loc);
   endfunction

   // Read-modify-write merge of pins and new data
   // Unmasked bits take the pin level, not the latch
   function automatic logic [5:0] rmw_merge(
      input logic [5:0] pins,
      input logic [5:0] data,
      input logic [5:0] mask
   );
      logic [5:0] keep;
      logic [5:0] take;
      keep = pins & ~mask;
      take = data & mask;
      return keep | take;
   endfunction

   // Widen a port value to a byte
   // Upper two bits always read zero
   function automatic logic [7:0] to_byte(input logic [5:0] v);
      return {2'h0, v};
   endfunction

   // Variant mask is a constant of the build
   assign impl = impl_bits(FULL_VARIANT);

   // Decode of the current access
   // One access per cycle at most; back to back is fine
   assign data_hit = addr_hit(core_req, SBGP_DATA_ADDR);
   assign dir_hit = addr_hit(core_req, SBGP_DIR_ADDR);
   assign rd_req = core_req.valid && !core_req.write;
   assign wr_req = core_req.valid && core_req.write;

   // Two stage synchroniser; first stage feeds only the second
   // Pins are asynchronous to the core, so nothing else reads sync1_r
   always_ff @(posedge clk) begin
      if (!rstn) begin
         sync1_r <= '0;
         pins_r <= '0;
      end else begin
         sync1_r <= pin_in;
         pins_r <= sync1_r;
      end
   end

   // Pins sampled now, merged with the masked new bits
   // A loaded output pin may read back low, and that level is kept
   assign latch_nxt = rmw_merge(pins_r, core_req.wdata[5:0],
      core_req.wmask[5:0]) & impl;

   // Direction writes take the low six bits of the byte; mask is ignored
   assign dir_nxt = core_req.wdata[5:0] & impl;

   // Output data latch
   // Latch reset value is a choice of this design
   always_ff @(posedge clk) begin
      if (!rstn) begin
         first_port_data_r <= SBGP_LATCH_RESET[5:0];
      end else if (data_hit && wr_req) begin
         first_port_data_r <= latch_nxt;
      end
   end

   // Direction register; every reset returns all pins to inputs
   always_ff @(posedge clk) begin
      if (!rstn) begin
         first_port_direction_r <= SBGP_DIR_RESET[5:0] & impl;
      end else if (dir_hit && wr_req) begin
         first_port_direction_r <= dir_nxt;
      end
   end

   // Read data mux; absent bits and locations read zero
   always_comb begin
      rdata_nxt = 8'h00;
      if (data_hit) begin
         rdata_nxt = to_byte(pins_r & impl);
      end else if (dir_hit) begin
         rdata_nxt = to_byte(first_port_direction_r);
      end
   end

   // Answer strobe one cycle after each read
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rsp_valid_r <= 1'h0;
      end else begin
         rsp_valid_r <= rd_req;
      end
   end

   // Read data holds until the next read
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rsp_rdata_r <= 8'h00;
      end else if (rd_req) begin
         rsp_rdata_r <= rdata_nxt;
      end
   end

   // Registered answer out
   assign core_rsp = '{valid: rsp_valid_r, rdata: rsp_rdata_r};

   // Pad hazards:
   //  - enables are combinational from flops, so they change
   //    right after the edge that writes a register
   //  - the open drain bit shows zero on its data line always,
   //    so a stray enable could never drive it high

   // Push-pull pins drive when output, port owned and present
   assign drive_en = ~first_port_direction_r
      & ~periph_en & impl;

   // Level that a driving pin would show
   assign pad_level = first_port_data_r;

   // Open drain bit pulls only while its latch holds zero
   assign od_pull_low = drive_en[SBGP_OD_BIT]
      & ~first_port_data_r[SBGP_OD_BIT];

   // Pad drive; enables are active low
   always_comb begin
      for (int i = 0; i < SBGP_WIDTH; i++) begin
         pin_out[i] = pad_level[i];
         pin_oe_n[i] = ~drive_en[i];
      end
      // Never a high level on the open drain bit
      pin_out[SBGP_OD_BIT] = 1'h0;
      pin_oe_n[SBGP_OD_BIT] = ~od_pull_low;
   end

   // Timer sees the synchronised level; counting is the timer's job
   assign timer_zero_clock_input = pins_r[SBGP_OD_BIT];
endmodule

`default_nettype wire

// ---- sim/sbgp_pins.sv ----
// Board model for the port pads.
// Assumes active low drive enables from the port.
`timescale 1ns/1ns
`default_nettype none
module sbgp_pins (
   // Port side
   input wire logic [5:0] pin_out,
   input wire logic [5:0] pin_oe_n,
   // Board level where released, then pad level
   input wire logic [5:0] ext,
   output logic [5:0] pin_in
);
   // Released pins show the board, never the last driven value
   assign pin_in = (pin_out & ~pin_oe_n) | (ext & pin_oe_n);
endmodule
`default_nettype wire

// ---- sim/sbgp_port_chk.sv ----
// Checker for the port pads and read answers.
// Assumes it is bound into sbgp_port on its one clock.
`timescale 1ns/1ns
`default_nettype none
module sbgp_port_chk (
   // Watched port signals
   input wire logic clk,
   input wire logic rstn,
   input wire sbgp_pkg::sbgp_req_t core_req,
   input wire sbgp_pkg::sbgp_rsp_t core_rsp,
   input wire logic [5:0] periph_en,
   input wire logic [5:0] pin_in,
   input wire logic [5:0] pin_out,
   input wire logic [5:0] pin_oe_n,
   input wire logic timer_zero_clock_input
);
   import sbgp_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // Read of the data location; a_rd_pins adds the synchroniser out of reset
   sequence s_rd_data;
      core_req.valid && !core_req.write && core_req.addr == SBGP_DATA_ADDR;
   endsequence
   a_od_low: assert property (!pin_out[4]) else $error("od high");
   a_periph_free: assert property (!(periph_en & ~pin_oe_n))
      else $error("periph pin driven");
   a_dir_set: assert property (core_req.valid && core_req.write &&
      core_req.addr == SBGP_DIR_ADDR |=>
      &(pin_oe_n | ~$past(core_req.wdata[5:0]))) else $error("dir set");
   a_rd_pins: assert property (s_rd_data ##0 $past(rstn) && $past(rstn, 2)
      |=> core_rsp.rdata[5:0] == $past(pin_in, 3)) else $error("rd pins");
   a_unmapped_read: assert property (core_req.valid && !core_req.write &&
      core_req.addr != SBGP_DATA_ADDR && core_req.addr != SBGP_DIR_ADDR
      |=> core_rsp.rdata == 8'h00) else $error("unmapped");
   a_upper_zero: assert property (core_rsp.valid |-> !core_rsp.rdata[7:6])
      else $error("upper bits");
   a_timer_feed: assert property ($past(rstn) && $past(rstn, 2) |->
      timer_zero_clock_input == $past(pin_in[4], 2)) else $error("timer");
   a_dir_reset: assert property ($past(rstn) == 1'h0 |-> &pin_oe_n)
      else $error("reset dir");
endmodule
bind sbgp_port sbgp_port_chk i_sbgp_port_chk (.clk(clk), .rstn(rstn),
   .core_req(core_req), .core_rsp(core_rsp), .periph_en(periph_en),
   .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
   .timer_zero_clock_input(timer_zero_clock_input));
`default_nettype wire

// ---- sim/sbgp_port_tb.sv ----
// Bench: reads noted in a queue, answers matched by a monitor.
// Assumes sbgp_pins as board and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module sbgp_port_tb;
   import sbgp_pkg::*;
   logic clk = 0, rstn = 0;
   sbgp_req_t req = '0;
   sbgp_rsp_t rsp;
   logic [5:0] pe = '0, ext = '0, po, oe, pi, m, e;
   logic tz;
   logic [31:0] s = 32'h81BC;
   logic [7:0] q[$];
   int miscompares = 0, samples_checked = 0;
   // 8 ns clock
   always #4 clk = ~clk;
   sbgp_port i_sbgp_port (.clk(clk), .rstn(rstn), .core_req(req),
      .core_rsp(rsp), .periph_en(pe), .pin_in(pi), .pin_out(po),
      .pin_oe_n(oe), .timer_zero_clock_input(tz));
   sbgp_pins i_sbgp_pins (.pin_out(po), .pin_oe_n(oe), .ext(ext), .pin_in(pi));
   function automatic [31:0] lf(input [31:0] v);
      lf = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(input string n, input [7:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s exp %h got %h", n, exp, got);
      end
   endtask
   // Byte access with write mask k; for a read d is the expected answer
   task automatic acc(input w, input [7:0] a, d, k = 8'hFF);
      @(posedge clk);
      req <= '{1'h1, w, a, d, k};
      if (!w) q.push_back(d);
      @(posedge clk);
      req.valid <= 1'h0;
   endtask
   // Oldest note against each answer
   always @(negedge clk) if (rsp.valid) chk("rdata", rsp.rdata, q.pop_front());
   task automatic stop_test;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Reset values, a masked read-modify-write, then random latch, direction, owner and board levels with readback
   initial begin
      repeat (3) @(posedge clk);
      rstn <= 1'h1;
      acc(0, SBGP_DIR_ADDR, SBGP_DIR_RESET);
      acc(0, 8'h95, 8'h00);
      $display("reset test done");
      ext <= 6'h2A;
      repeat (3) @(posedge clk);
      acc(1, SBGP_DATA_ADDR, 8'h05, 8'h0F);
      acc(1, SBGP_DIR_ADDR, 8'h00);
      repeat (4) @(posedge clk);
      acc(0, SBGP_DATA_ADDR, {2'h0, 6'h2A & ~6'h0F | 6'h05});
      $display("rmw test done");
      for (int i = 0; i < 20; i++) begin
         s = lf(lf(s));
         ext <= s[5:0];
         pe <= s[13:8];
         acc(1, SBGP_DATA_ADDR, {2'h0, s[21:16]});
         acc(1, SBGP_DIR_ADDR, {2'h0, s[29:24]});
         m = ~s[29:24] & ~pe & ~{1'h0, s[20], 4'h0};
         repeat (4) @(posedge clk);
         e = s[21:16] & m | ext & ~m;
         @(negedge clk);
         chk("timer", {7'h0, tz}, {7'h0, e[4]});
         acc(0, SBGP_DATA_ADDR, {2'h0, e});
      end
      repeat (3) @(posedge clk);
      $display("pin test done");
      stop_test;
   end
   // Watchdog well past 20 rounds of some 10 cycles
   initial begin
      #20000;
      miscompares++;
      stop_test;
   end
endmodule
`default_nettype wire
